// ---- ppcd_defines.svh ----
// Register offsets, field positions and reset values for the pin change detector
`ifndef PPCD_DEFINES_SVH
`define PPCD_DEFINES_SVH
`define PPCD_ADDR_RISE_EN 4'h0
`define PPCD_ADDR_FALL_EN 4'h1
`define PPCD_ADDR_FLAGS 4'h2
`define PPCD_ADDR_CTRL 4'h3
`define PPCD_ADDR_IRQ_STAT 4'h4
`define PPCD_ADDR_IRQ_CLR 4'h5
`define PPCD_ADDR_IRQ_EN 4'h6
`define PPCD_CTRL_MASTER_EN_BIT 3
`define PPCD_CTRL_SUMMARY_BIT 0
`define PPCD_RESET_BYTE 8'h00
`define PPCD_RESET_PINS 4'h0
`endif

// ---- ppcd_pkg.sv ----
// Types shared by the pin change detector files
package ppcd_pkg;
  typedef logic [7:0] ppcd_byte_type;
  typedef logic [3:0] ppcd_addr_type;
  typedef logic [3:0] ppcd_pins_type;
endpackage

// ---- ppcd_edge_detect.sv ----
// Per-pin synchroniser and edge detector
`timescale 1ns/1ns
module ppcd_edge_detect #(
  parameter int NPINS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and enables
  input wire logic [NPINS-1:0] pinsIn,
  input wire logic [NPINS-1:0] riseEn,
  input wire logic [NPINS-1:0] fallEn,
  // Detected enabled edges, one-cycle pulses
  output logic [NPINS-1:0] edgeHit
);
  logic [NPINS-1:0] sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
  logic primed_q, primed_d;

  // Two flops, then a previous-sample flop to compare against
  always_comb begin
    sync1_d = pinsIn;
    sync2_d = sync1_q;
    prev_d = sync2_q;
    primed_d = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
      primed_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      primed_q <= primed_d;
    end
  end

  // Primed gate masks only the first cycle after reset; a pin high at reset still shows as a rise once it reaches sync2_q
  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      assign edgeHit[i] = primed_q & (
        (riseEn[i] & sync2_q[i] & ~prev_q[i]) |
        (fallEn[i] & ~sync2_q[i] & prev_q[i]));
    end
  endgenerate
endmodule

// ---- port_pin_change_detector.sv ----
// Top of the four-pin change detector with its register port and interrupt
`timescale 1ns/1ns
`include "ppcd_defines.svh"
module port_pin_change_detector #(
  parameter int NPINS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire ppcd_pkg::ppcd_addr_type regAddr,
  input wire ppcd_pkg::ppcd_byte_type regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output ppcd_pkg::ppcd_byte_type regRdata,
  // Port pins and sleep state
  input wire logic [NPINS-1:0] port_pins,
  input wire logic sleeping,
  // Outputs to the core
  output logic changeIrq,
  output logic wakeReq,
  output logic irqOut
);
  import ppcd_pkg::*;

  logic [NPINS-1:0] riseEn_q, riseEn_d, fallEn_q, fallEn_d, flags_q, flags_d;
  logic masterEn_q, masterEn_d;
  logic irqStat_q, irqStat_d, irqEn_q, irqEn_d;
  logic changeIrq_q, changeIrq_d, wakeReq_q, wakeReq_d, irqOut_q, irqOut_d;
  ppcd_byte_type rdata_q, rdata_d;
  logic [NPINS-1:0] edgeHit;
  logic anyHit, summary;

  // Write decode, used for every writable register
  function automatic logic wrHit(input ppcd_addr_type a, input ppcd_addr_type target,
                                 input logic wr);
    wrHit = wr && (a == target);
  endfunction

  // Pad a pin vector into the low bits of a byte
  function automatic ppcd_byte_type padPins(input logic [NPINS-1:0] v);
    padPins = {{(8 - NPINS){1'b0}}, v};
  endfunction

  ppcd_edge_detect #(
    .NPINS(NPINS)
  ) u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinsIn(port_pins),
    .riseEn(riseEn_q),
    .fallEn(fallEn_q),
    .edgeHit(edgeHit)
  );

  // Detection runs regardless of the master enable
  assign anyHit = |edgeHit;
  assign summary = |flags_q;

  // Configuration registers
  always_comb begin
    riseEn_d = riseEn_q;
    fallEn_d = fallEn_q;
    masterEn_d = masterEn_q;
    irqEn_d = irqEn_q;
    if (wrHit(regAddr, `PPCD_ADDR_RISE_EN, regWr)) begin
      riseEn_d = regWdata[NPINS-1:0];
    end
    if (wrHit(regAddr, `PPCD_ADDR_FALL_EN, regWr)) begin
      fallEn_d = regWdata[NPINS-1:0];
    end
    if (wrHit(regAddr, `PPCD_ADDR_CTRL, regWr)) begin
      masterEn_d = regWdata[`PPCD_CTRL_MASTER_EN_BIT];
    end
    if (wrHit(regAddr, `PPCD_ADDR_IRQ_EN, regWr)) begin
      irqEn_d = regWdata[0];
    end
  end

  // Flags: a write stores the value, a same-cycle edge always wins
  always_comb begin
    flags_d = flags_q | edgeHit;
    if (wrHit(regAddr, `PPCD_ADDR_FLAGS, regWr)) begin
      flags_d = regWdata[NPINS-1:0] | edgeHit;
    end
  end

  // Sticky status set by any enabled edge; software clears by writing one
  always_comb begin
    irqStat_d = irqStat_q;
    if (wrHit(regAddr, `PPCD_ADDR_IRQ_CLR, regWr) && regWdata[0]) begin
      irqStat_d = 1'b0;
    end
    if (anyHit) begin
      irqStat_d = 1'b1;
    end
  end

  // Outputs to the core follow the new flag and status state, so they line up with it
  always_comb begin
    changeIrq_d = masterEn_d & (|flags_d);
    wakeReq_d = sleeping & masterEn_d & (|flags_d);
    irqOut_d = irqEn_d & irqStat_d;
  end

  // Read mux; data appears one cycle after the strobe, unmapped reads zero
  always_comb begin
    rdata_d = `PPCD_RESET_BYTE;
    if (regRd) begin
      unique case (regAddr)
        `PPCD_ADDR_RISE_EN: rdata_d = padPins(riseEn_q);
        `PPCD_ADDR_FALL_EN: rdata_d = padPins(fallEn_q);
        `PPCD_ADDR_FLAGS: rdata_d = padPins(flags_q);
        `PPCD_ADDR_CTRL: begin
          rdata_d[`PPCD_CTRL_MASTER_EN_BIT] = masterEn_q;
          rdata_d[`PPCD_CTRL_SUMMARY_BIT] = summary;
        end
        `PPCD_ADDR_IRQ_STAT: rdata_d[0] = irqStat_q;
        `PPCD_ADDR_IRQ_EN: rdata_d[0] = irqEn_q;
        default: rdata_d = `PPCD_RESET_BYTE;
      endcase
    end
  end

  // All state registers; reset clears everything
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      riseEn_q <= `PPCD_RESET_PINS;
      fallEn_q <= `PPCD_RESET_PINS;
      flags_q <= `PPCD_RESET_PINS;
      masterEn_q <= 1'b0;
      irqStat_q <= 1'b0;
      irqEn_q <= 1'b0;
      changeIrq_q <= 1'b0;
      wakeReq_q <= 1'b0;
      irqOut_q <= 1'b0;
      rdata_q <= `PPCD_RESET_BYTE;
    end else begin
      riseEn_q <= riseEn_d;
      fallEn_q <= fallEn_d;
      flags_q <= flags_d;
      masterEn_q <= masterEn_d;
      irqStat_q <= irqStat_d;
      irqEn_q <= irqEn_d;
      changeIrq_q <= changeIrq_d;
      wakeReq_q <= wakeReq_d;
      irqOut_q <= irqOut_d;
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
  assign changeIrq = changeIrq_q;
  assign wakeReq = wakeReq_q;
  assign irqOut = irqOut_q;

  // Checks
  sequence s_hit_with_en;
    anyHit && masterEn_d;
  endsequence

  // A software write aimed at the flag register
  sequence s_flag_write;
    regWr && regAddr == `PPCD_ADDR_FLAGS;
  endsequence

  // Flags only drop through a flag write, never on their own
  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    !(regWr && regAddr == `PPCD_ADDR_FLAGS) |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped without a write");

  // Quiet pins and no write leave the flags untouched
  chk_flags_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (!anyHit && !(regWr && regAddr == `PPCD_ADDR_FLAGS)) |=> flags_q == $past(flags_q))
    else $error("flags moved with no cause");

  // A flag write with no edge stores exactly the written bits
  chk_flag_store: assert property (@(posedge sys_clk) disable iff (rst)
    s_flag_write ##0 (edgeHit == '0) |=> flags_q == $past(regWdata[NPINS-1:0]))
    else $error("flag write not stored");

  // A hit can only come from a pin with an enable bit set
  chk_hit_needs_en: assert property (@(posedge sys_clk) disable iff (rst)
    (edgeHit & ~(riseEn_q | fallEn_q)) == '0)
    else $error("hit on a pin with no enable");

  // The core request needs both the master enable and a set flag
  chk_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    changeIrq |-> masterEn_q && flags_q != '0)
    else $error("interrupt without cause");

  // And it is raised whenever both hold
  chk_irq_raised: assert property (@(posedge sys_clk) disable iff (rst)
    (masterEn_q && flags_q != '0) |-> changeIrq)
    else $error("interrupt missing");

  // Wake only from sleep, with master enable and a flag
  chk_wake_cause: assert property (@(posedge sys_clk) disable iff (rst)
    wakeReq |-> masterEn_q && flags_q != '0 && $past(sleeping))
    else $error("wake without cause");

  // Any enabled edge sets the sticky status bit
  chk_stat_set: assert property (@(posedge sys_clk) disable iff (rst)
    anyHit |=> irqStat_q)
    else $error("status not set by edge");

  // Status set wins over a clear in the same cycle
  chk_stat_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
    (anyHit && regWr && regAddr == `PPCD_ADDR_IRQ_CLR && regWdata[0]) |=> irqStat_q)
    else $error("clear beat a new edge");

  // The level interrupt follows status and its enable
  chk_irq_out_level: assert property (@(posedge sys_clk) disable iff (rst)
    irqOut |-> irqEn_q && irqStat_q)
    else $error("level interrupt without cause");

  // Read data stands only in the cycle after the strobe
  chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");

  // Rise enable write lands as written
  chk_rise_write: assert property (@(posedge sys_clk) disable iff (rst)
    (regWr && regAddr == `PPCD_ADDR_RISE_EN) |=> riseEn_q == $past(regWdata[NPINS-1:0]))
    else $error("rise enable write lost");

  // Fall enable write lands as written
  chk_fall_write: assert property (@(posedge sys_clk) disable iff (rst)
    (regWr && regAddr == `PPCD_ADDR_FALL_EN) |=> fallEn_q == $past(regWdata[NPINS-1:0]))
    else $error("fall enable write lost");

  // Flag read returns the flags of the strobe cycle
  chk_flag_read: assert property (@(posedge sys_clk) disable iff (rst)
    (regRd && regAddr == `PPCD_ADDR_FLAGS) |=> regRdata[3:0] == $past(flags_q))
    else $error("flag read wrong");

  // The write-only clear register and unmapped slots read zero
  chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (regRd && (regAddr == `PPCD_ADDR_IRQ_CLR || regAddr > `PPCD_ADDR_IRQ_EN)) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");

  chk_edge_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
    edgeHit[0] |=> flags_q[0])
    else $error("edge did not set flag");
  chk_flag_write_race: assert property (@(posedge sys_clk) disable iff (rst)
    s_flag_write ##0 edgeHit[1] |=> flags_q[1])
    else $error("edge lost during flag write");
  chk_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (regWr && regAddr == `PPCD_ADDR_FLAGS && !regWdata[2] && !edgeHit[2])
    |=> !flags_q[2])
    else $error("flag not cleared by write");
  chk_summary_or: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr == `PPCD_ADDR_CTRL |=> regRdata[0] == $past(|flags_q))
    else $error("summary not OR of flags");
  chk_irq_master: assert property (@(posedge sys_clk) disable iff (rst)
    changeIrq |-> $past(masterEn_d))
    else $error("interrupt without master enable");
  chk_irq_request: assert property (@(posedge sys_clk) disable iff (rst)
    s_hit_with_en |=> changeIrq)
    else $error("no interrupt on enabled edge");
  chk_wake_master: assert property (@(posedge sys_clk) disable iff (rst)
    (sleeping && anyHit && masterEn_d) |=> wakeReq ##0 flags_q != '0)
    else $error("no wake with flag set");
  chk_no_rise_when_off: assert property (@(posedge sys_clk) disable iff (rst)
    (!riseEn_q[3] && !fallEn_q[3]) |-> !edgeHit[3])
    else $error("edge on disabled pin");
  chk_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
    $past(regRd) && $past(regAddr) <= `PPCD_ADDR_FLAGS |-> regRdata[7:4] == 4'h0)
    else $error("upper bits not zero");
endmodule

// ---- ppcd_pin_model.sv ----
// Far-side model of the four port pins, driven by the bench
`timescale 1ns/1ns
module ppcd_pin_model (
  // Clock
  input wire logic sys_clk,
  // Requested levels
  input wire logic [3:0] targetPins,
  // Pin levels
  output logic [3:0] pinLevels
);
  // Pins move once per request and then hold, so each change is one edge
  always_ff @(posedge sys_clk) begin
    pinLevels <= targetPins;
  end
endmodule

// ---- test_port_pin_change_detector.sv ----
// Self-checking bench for the four-pin change detector
`timescale 1ns/1ns
module test_port_pin_change_detector;
  import ppcd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  ppcd_addr_type regAddr = 4'h0;
  ppcd_byte_type regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sleeping = 1'b0;
  logic [3:0] pinT = 4'h0;
  logic [3:0] pinsW;
  ppcd_byte_type regRdata, rv;
  logic changeIrq, wakeReq, irqOut;
  int n_fail = 0;
  int total_checks = 0;
  // Half period of 5 ns gives 100 MHz
  always #5 sys_clk = ~sys_clk;
  ppcd_pin_model PINS (.sys_clk(sys_clk), .targetPins(pinT), .pinLevels(pinsW));
  port_pin_change_detector #(.NPINS(4)) DUT (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .port_pins(pinsW), .sleeping(sleeping), .changeIrq(changeIrq), .wakeReq(wakeReq),
    .irqOut(irqOut));
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compare one byte-wide result
  task automatic chk(input ppcd_byte_type got, input ppcd_byte_type exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input ppcd_addr_type a, input ppcd_byte_type d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // Read strobe, data sampled in the following cycle only
  task automatic rd(input ppcd_addr_type a, output ppcd_byte_type d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Pin path is two sync flops plus compare; eight cycles covers it with margin
  task automatic settle();
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  task automatic reg_defaults();
    for (int i = 0; i < 4; i++) begin
      rd(i[3:0], rv);
      chk(rv, 8'h00);
    end
    rd(4'h7, rv);
    chk(rv, 8'h00);
    wr(4'h0, 8'hff);
    rd(4'h0, rv);
    chk(rv, 8'h0f);
    wr(4'h1, 8'hff);
    rd(4'h1, rv);
    chk(rv, 8'h0f);
  endtask
  // Mixed enables, master clear: flags still set, core irq held off
  task automatic edges_no_master();
    wr(4'h0, 8'h05);
    wr(4'h1, 8'h06);
    wr(4'h6, 8'h01);
    pinT <= 4'hf;
    settle();
    chk({7'h00, changeIrq}, 8'h00);
    chk({7'h00, irqOut}, 8'h01);
    rd(4'h2, rv);
    chk(rv, 8'h05);
    rd(4'h3, rv);
    chk(rv, 8'h01);
    // Software clears every flag: rv AND its inverse is always zero
    rd(4'h2, rv);
    wr(4'h2, rv & (rv ^ 8'hff));
    rd(4'h2, rv);
    chk(rv, 8'h00);
    rd(4'h3, rv);
    chk(rv, 8'h00);
    pinT <= 4'h0;
    settle();
    rd(4'h2, rv);
    chk(rv, 8'h06);
    wr(4'h5, 8'h01);
    #1;
    chk({7'h00, irqOut}, 8'h00);
  endtask
  // Pin 1 edge lands in the very cycle of a flag write of zero
  task automatic flag_write_race();
    wr(4'h0, 8'h07);
    pinT <= 4'h3;
    repeat (2) @(posedge sys_clk);
    wr(4'h2, 8'h00);
    rd(4'h2, rv);
    chk(rv, 8'h02);
  endtask
  // Master enable, then an edge while asleep
  task automatic master_and_sleep();
    wr(4'h3, 8'h08);
    #1;
    chk({7'h00, changeIrq}, 8'h01);
    wr(4'h2, 8'h00);
    sleeping <= 1'b1;
    settle();
    chk({7'h00, wakeReq}, 8'h00);
    pinT <= 4'h1;
    settle();
    chk({7'h00, wakeReq}, 8'h01);
    rd(4'h2, rv);
    chk(rv, 8'h01);
    wr(4'h3, 8'h00);
    #1;
    chk({7'h00, wakeReq}, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    reg_defaults();
    edges_no_master();
    master_and_sleep();
    flag_write_race();
    conclude();
  end
endmodule
